// *** sio_map.svh ***
// Register map, field positions, reset values and timing counts of the serial unit.
// Assumes a 32-bit APB register bus and byte addresses.
`ifndef SIO_MAP_SVH
`define SIO_MAP_SVH
`define SIO_CTRL_OFS  8'h00
`define SIO_STAT_OFS  8'h04
`define SIO_TXB_OFS   8'h08
`define SIO_RXB_OFS   8'h0C
`define SIO_C_RUN     7
`define SIO_C_ABORT   6
`define SIO_C_MODE    5:4
`define SIO_C_DIR     3
`define SIO_C_CKS     2:0
`define SIO_S_TXU     3
`define SIO_S_RXO     2
`define SIO_CTRL_RST  8'h00
`define SIO_STAT_RST  8'h20
`define SIO_CKS_EXT   3'h7
`define SIO_HALF_BASE 4
`define SIO_BITS      4'h8
`define SIO_LAST_BIT  4'h7
`endif

// *** sio_peer.sv ***
// Far-side serial peer: clocks bytes in with its own clock, or follows the device's clock.
// Assumes the bench resolves the clock wire from both drivers and calls xfer between frames.
module sio_peer (
  // Link pins
  output logic      sck,
  output logic      sdo,
  input  wire logic devOut,
  input  wire logic sckWire,
  input  wire logic devDrive
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] slvTx;
  logic [7:0] slvGot;
  int         falls;
  initial begin
    sck = 1'b1;
    sdo = 1'b1;
    slvTx = 8'h00;
    slvGot = 8'h00;
    falls = 0;
  end
  ////////////////////////////////////////////////////////////
  // Clock stands high outside frames; the long low phase lets the device output settle
  task automatic xfer(input logic [7:0] b, input logic lsb, output logic [7:0] got);
    int idx;
    // Start off the core clock's edges so no pin change races a sampling flop
    #6;
    for (int i = 0; i < 8; i++) begin
      idx = lsb ? i : 7 - i;
      sck = 1'b0;
      sdo = b[idx];
      #125;
      sck = 1'b1;
      got[idx] = devOut;
      #75;
    end
    sdo = ~sdo;
  endtask
  ////////////////////////////////////////////////////////////
  // Follower of the device's own clock, MSB first
  always @(negedge sckWire) if (devDrive === 1'b1) begin
    sdo = slvTx[7 - (falls % 8)];
    falls++;
  end
  always @(posedge sckWire) if (devDrive === 1'b1) slvGot = {slvGot[6:0], devOut};
endmodule

// *** sio_pkg.sv ***
// Types shared by the serial unit.
// Assumes nothing beyond a SystemVerilog compiler.
package sio_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_HOLD  = 3'h2,
    ST_SHIFT = 3'h4
  } sio_state_e;
  typedef enum logic [1:0] {
    MODE_TX   = 2'h0,
    MODE_RX   = 2'h1,
    MODE_TXRX = 2'h2,
    MODE_RSV  = 2'h3
  } sio_mode_e;
endpackage

// *** sio_rxtx.sv ***
// Receive and transmit/receive engine of an 8-bit synchronous serial unit with APB registers.
// Assumes core_clk at 40 MHz; serial clock and data pins are asynchronous to it.
//
// Overview of operation
// - Clearing run in receive finishes current byte.
// - Abort halts at once, clears run, flags, shift registers and buffers.
// - Overrun set: new data discarded, buffers kept.
// - Byte done with buffer full sets overrun.
// - After overrun, second read returns shift register.
// - Clearing overrun also clears receive-full.
// - After run clear, stop after eight pulses.
// - No interrupt while overrun stays uncorrected.
// - Mode 10 selects full duplex.
// - Active flag set on first falling edge.
// - Output on falling, input on rising edge.
// - Shift-count flag high first to eighth fall.
// - Tx empty at rise; rx full plus interrupt.
// - Internal clock starts within one serial period.
// - External first fall loads the shift register.
// - Tx write clears empty; rx read clears full.
// - Internal clock waits high for read and write.
// - Underrun sets flag, data pin held high.
// - Full duplex stop finishes byte, pin high.
// - Direction zero MSB first, one LSB first.
// - Mode 01 selects receive only.
// - Receive only: byte stored, full set, interrupt.
`include "sio_map.svh"

module sio_rxtx
  import sio_pkg::*;
#(
  parameter int HALF_BASE = `SIO_HALF_BASE
) (
  // Clock, reset, enable
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        clkEn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial pins
  input  wire logic        serialClockPinIn,
  output logic             serialClockPinOut,
  output logic             serialClockPinOe,
  input  wire logic        serialInPin,
  output logic             serialOutPin,
  // Interrupt
  output logic             serialIrq
);

  if (HALF_BASE < 1 || HALF_BASE > 256) begin : g_chk
    $error("HALF_BASE must lie in 1..256");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers and bus decode

  logic       runReg;
  sio_mode_e  modeReg;
  logic       dirReg;
  logic [2:0] cksReg;
  sio_state_e stateReg;
  logic       sefReg, txEmptyReg, rxFullReg, txUnderReg, rxOverReg;
  logic [7:0] txBufReg, rxBufReg, txShReg, rxShReg;
  logic [3:0] fallCntReg, riseCntReg;
  logic       txLoadedReg, rxReadSeenReg, sdoReg, irqReg;
  logic       sckOutReg;
  logic [15:0] divCntReg;
  logic       sckS1, sckS2, sckS3, sdiS1, sdiS2;

  logic hitCtrl, hitStat, hitTx, hitRx, apbWr, apbRd;
  logic abortWr, ctrlWr, txWr, rxRd, errClrTx, errClrRx;

  assign hitCtrl  = paddr == `SIO_CTRL_OFS;
  assign hitStat  = paddr == `SIO_STAT_OFS;
  assign hitTx    = paddr == `SIO_TXB_OFS;
  assign hitRx    = paddr == `SIO_RXB_OFS;
  assign apbWr    = psel & penable & pwrite;
  assign apbRd    = psel & penable & ~pwrite;
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~(hitCtrl | hitStat | hitTx | hitRx);
  assign ctrlWr   = apbWr & hitCtrl;
  assign abortWr  = ctrlWr & pwdata[`SIO_C_ABORT];
  // Writes while the buffer still holds unsent data are dropped
  assign txWr     = apbWr & hitTx & txEmptyReg;
  assign rxRd     = apbRd & hitRx;
  assign errClrTx = apbWr & hitStat & ~pwdata[`SIO_S_TXU];
  assign errClrRx = apbWr & hitStat & ~pwdata[`SIO_S_RXO];

  // Control register; abort bit is an action and reads back zero
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      runReg  <= 1'b0;
      modeReg <= MODE_TX;
      dirReg  <= 1'b0;
      cksReg  <= 3'h0;
    end else if (clkEn && ctrlWr) begin
      runReg  <= pwdata[`SIO_C_RUN] & ~pwdata[`SIO_C_ABORT];
      modeReg <= sio_mode_e'(pwdata[`SIO_C_MODE]);
      dirReg  <= pwdata[`SIO_C_DIR];
      cksReg  <= pwdata[`SIO_C_CKS];
    end
  end

  // Read data is captured in the setup cycle so that prdata comes from a flop
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (clkEn && psel && !penable && !pwrite) begin
      case (1'b1)
        hitCtrl: prdata <= {24'h00_0000, runReg, 1'b0, modeReg, dirReg, cksReg};
        hitStat: prdata <= {24'h00_0000, stateReg != ST_IDLE, sefReg, txEmptyReg,
                            rxFullReg, txUnderReg, rxOverReg, 2'h0};
        hitRx:   prdata <= {24'h00_0000, rxReadSeenReg ? rxShReg : rxBufReg};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial clock: pin synchroniser and internal generator

  logic isExt, modeOk, waitInt, startOk, genGo, intEdge;
  logic fallEv, riseEv;
  logic [15:0] halfCnt;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      {sckS1, sckS2, sckS3} <= 3'h7;
      {sdiS1, sdiS2}        <= 2'h3;
    end else if (clkEn) begin
      sckS1 <= serialClockPinIn;
      sckS2 <= sckS1;
      sckS3 <= sckS2;
      sdiS1 <= serialInPin;
      sdiS2 <= sdiS1;
    end
  end

  assign isExt   = cksReg == `SIO_CKS_EXT;
  assign modeOk  = modeReg == MODE_RX || modeReg == MODE_TXRX;
  // Auto-wait: hold the clock high until software has serviced the buffers
  assign waitInt = rxFullReg | (modeReg == MODE_TXRX & txEmptyReg);
  assign startOk = runReg & modeOk & (isExt | ~waitInt);
  assign genGo   = ~sckOutReg | (stateReg == ST_SHIFT ? fallCntReg != `SIO_BITS : startOk);
  assign halfCnt = 16'(HALF_BASE) << cksReg;
  assign intEdge = ~isExt & genGo & (divCntReg == halfCnt - 16'h0001);
  assign fallEv  = isExt ? (sckS3 & ~sckS2) : (intEdge & sckOutReg);
  assign riseEv  = isExt ? (~sckS3 & sckS2) : (intEdge & ~sckOutReg);

  // Counter rests at zero while idle, so a start needs at most one period
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sckOutReg <= 1'b1;
      divCntReg <= 16'h0000;
    end else if (clkEn) begin
      if (abortWr || isExt || !genGo) begin
        divCntReg <= 16'h0000;
        if (abortWr || isExt) sckOutReg <= 1'b1;
      end else if (intEdge) begin
        divCntReg <= 16'h0000;
        sckOutReg <= ~sckOutReg;
      end else begin
        divCntReg <= divCntReg + 16'h0001;
      end
    end
  end

  assign serialClockPinOut = sckOutReg;
  assign serialClockPinOe  = ~isExt;

  ////////////////////////////////////////////////////////////////////////////
  // Transfer engine

  logic startEv, underEv, loadEv, doneEv, storeEv, overEv;
  logic [7:0] rxShIn, txShNext;

  function automatic logic firstBit(input logic dir, input logic [7:0] d);
    firstBit = dir ? d[0] : d[7];
  endfunction

  // A start is taken only on a falling edge, so external loads follow the pin
  assign startEv  = fallEv & runReg & modeOk & (stateReg != ST_SHIFT);
  assign underEv  = startEv & modeReg == MODE_TXRX & txEmptyReg;
  assign loadEv   = startEv & modeReg == MODE_TXRX & ~txEmptyReg;
  assign doneEv   = stateReg == ST_SHIFT & riseEv & riseCntReg == `SIO_LAST_BIT;
  // Full buffer at completion means overrun; internal clock never gets here full
  assign overEv   = doneEv & ~rxOverReg & rxFullReg;
  assign storeEv  = doneEv & ~rxOverReg & ~rxFullReg;
  assign rxShIn   = dirReg ? {sdiS2, rxShReg[7:1]} : {rxShReg[6:0], sdiS2};
  assign txShNext = dirReg ? {1'b1, txShReg[7:1]} : {txShReg[6:0], 1'b1};

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stateReg    <= ST_IDLE;
      fallCntReg  <= 4'h0;
      riseCntReg  <= 4'h0;
      txShReg     <= 8'h00;
      rxShReg     <= 8'h00;
      txLoadedReg <= 1'b0;
      sdoReg      <= 1'b1;
    end else if (clkEn) begin
      if (abortWr) begin
        stateReg    <= ST_IDLE;
        fallCntReg  <= 4'h0;
        riseCntReg  <= 4'h0;
        txShReg     <= 8'h00;
        rxShReg     <= 8'h00;
        txLoadedReg <= 1'b0;
        sdoReg      <= 1'b1;
      end else begin
        case (stateReg)
          ST_IDLE, ST_HOLD: begin
            sdoReg <= 1'b1;
            if (stateReg == ST_HOLD && !runReg) begin
              stateReg <= ST_IDLE;
            end else if (startEv) begin
              stateReg   <= ST_SHIFT;
              fallCntReg <= 4'h1;
              riseCntReg <= 4'h0;
              if (loadEv) begin
                txShReg     <= txBufReg;
                txLoadedReg <= 1'b1;
                sdoReg      <= firstBit(dirReg, txBufReg);
              end else begin
                sdoReg <= 1'b1;
              end
            end
          end
          ST_SHIFT: begin
            if (fallEv && fallCntReg != `SIO_BITS) begin
              fallCntReg <= fallCntReg + 4'h1;
              txShReg    <= txShNext;
              if (modeReg == MODE_TXRX && !txUnderReg) sdoReg <= firstBit(dirReg, txShNext);
            end
            if (riseEv) begin
              riseCntReg  <= riseCntReg + 4'h1;
              txLoadedReg <= 1'b0;
              if (!rxOverReg) rxShReg <= rxShIn;
              if (doneEv) begin
                // Byte finished: stop if run was cleared; last bit stands past this rise for hold
                stateReg <= runReg ? ST_HOLD : ST_IDLE;
              end
            end
          end
          default: stateReg <= ST_IDLE;
        endcase
      end
    end
  end

  assign serialOutPin = sdoReg;

  ////////////////////////////////////////////////////////////////////////////
  // Status flags, buffers and interrupt

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sefReg <= 1'b0;
    end else if (clkEn) begin
      if (abortWr) sefReg <= 1'b0;
      else if (startEv) sefReg <= 1'b1;
      else if (stateReg == ST_SHIFT && fallEv && fallCntReg == `SIO_LAST_BIT) sefReg <= 1'b0;
    end
  end

  // Set wins over a clearing write in the same cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      txEmptyReg <= 1'b1;
      txBufReg   <= 8'h00;
    end else if (clkEn) begin
      if (abortWr) begin
        txEmptyReg <= 1'b1;
        txBufReg   <= 8'h00;
      end else begin
        if (riseEv && stateReg == ST_SHIFT && txLoadedReg) txEmptyReg <= 1'b1;
        else if (txWr) txEmptyReg <= 1'b0;
        if (txWr) txBufReg <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxFullReg     <= 1'b0;
      rxBufReg      <= 8'h00;
      rxReadSeenReg <= 1'b0;
    end else if (clkEn) begin
      if (abortWr) begin
        rxFullReg     <= 1'b0;
        rxBufReg      <= 8'h00;
        rxReadSeenReg <= 1'b0;
      end else begin
        if (storeEv) begin
          rxFullReg <= 1'b1;
          rxBufReg  <= rxShIn;
        end else if (errClrRx && rxOverReg) begin
          rxFullReg <= 1'b0;
        end else if (rxRd && !rxOverReg && !overEv) begin
          rxFullReg <= 1'b0;
        end
        if (errClrRx && rxOverReg) rxReadSeenReg <= 1'b0;
        else if (rxRd && rxOverReg) rxReadSeenReg <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      txUnderReg <= 1'b0;
      rxOverReg  <= 1'b0;
    end else if (clkEn) begin
      if (abortWr) begin
        txUnderReg <= 1'b0;
        rxOverReg  <= 1'b0;
      end else begin
        if (underEv) txUnderReg <= 1'b1;
        else if (errClrTx) txUnderReg <= 1'b0;
        if (overEv) rxOverReg <= 1'b1;
        else if (errClrRx) rxOverReg <= 1'b0;
      end
    end
  end

  // One pulse per byte completed while overrun is clear; underrun is reported with the byte's end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqReg <= 1'b0;
    end else if (clkEn) begin
      irqReg <= doneEv & ~rxOverReg & ~abortWr;
    end
  end

  assign serialIrq = irqReg;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  AST_ABORT_CLEARS: assert property (
    clkEn && abortWr |=> stateReg == ST_IDLE && !runReg && txEmptyReg && !rxFullReg && rxBufReg == 8'h00)
    else $error("abort did not clear the unit");
  AST_OVR_KEEPS: assert property (
    clkEn && rxOverReg && !abortWr |=> $stable(rxBufReg) && $stable(rxShReg))
    else $error("data changed during overrun");
  AST_OVR_SET: assert property (
    clkEn && doneEv && rxFullReg && !rxOverReg && !abortWr |=> rxOverReg && rxFullReg && serialIrq)
    else $error("overrun not flagged");
  AST_CLR_OVR_RXF: assert property (
    clkEn && errClrRx && rxOverReg && !abortWr |=> !rxFullReg && !rxOverReg)
    else $error("receive full kept after overrun clear");
  AST_NO_IRQ_OVR: assert property (
    rxOverReg && $past(rxOverReg) |-> !serialIrq)
    else $error("interrupt raised during overrun");
  AST_ACT_ON_FALL: assert property (
    clkEn && stateReg == ST_IDLE && !fallEv |=> stateReg == ST_IDLE)
    else $error("transfer active without a falling edge");
  AST_SEF_OUTSIDE: assert property (
    stateReg != ST_SHIFT |-> !sefReg)
    else $error("shift count flag high outside a byte");
  AST_STORE_IRQ: assert property (
    clkEn && storeEv && !abortWr |=> rxFullReg && serialIrq && rxBufReg == $past(rxShIn))
    else $error("byte not stored with interrupt");
  AST_TXWR_CLR: assert property (
    clkEn && txWr && !abortWr |=> !txEmptyReg ##0 txBufReg == $past(pwdata[7:0]))
    else $error("transmit write did not clear empty");
  AST_WAIT_HIGH: assert property (
    !isExt && stateReg == ST_HOLD && rxFullReg |-> serialClockPinOut && !intEdge)
    else $error("clock not held during auto-wait");
  AST_UNDER_HIGH: assert property (
    txUnderReg && stateReg == ST_SHIFT |-> serialOutPin)
    else $error("data pin not high on underrun");
  AST_STOP_IDLE: assert property (
    clkEn && doneEv && !runReg && !abortWr |=> stateReg == ST_IDLE ##1 serialOutPin)
    else $error("unit did not stop after the byte");
  AST_FIRST_BIT: assert property (
    clkEn && loadEv && !abortWr |=> serialOutPin == (dirReg ? $past(txBufReg[0]) : $past(txBufReg[7])))
    else $error("wrong first bit");
  AST_RESERVED: assert property (
    modeReg == MODE_RSV && stateReg == ST_IDLE |=> stateReg == ST_IDLE)
    else $error("transfer started in reserved mode");

  COV_STORE: cover property (storeEv && modeReg == MODE_RX);
  COV_DUPLEX: cover property (storeEv && modeReg == MODE_TXRX);
  COV_OVERRUN: cover property (overEv);
  COV_UNDERRUN: cover property (underEv);

endmodule

// *** tb.sv ***
// Self-checking bench of the serial engine with an external peer model.
// Assumes the register map header and a fast clock-rate parameter.
`include "sio_map.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk;
  logic        rst_n;
  logic        clkEn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sckOut;
  logic        sckOe;
  logic        peerSck;
  logic        sckWire;
  logic        sdiPin;
  logic        sdoPin;
  logic        serialIrq;
  logic [31:0] q;
  logic        e;
  logic [7:0]  got;
  logic [7:0]  tx;
  logic [7:0]  rx;
  logic [7:0]  rxq[$];
  int          errors;
  int          checks_done;
  int          irqCount;
  int          expIrq;
  int          cycles;
  assign sckWire = sckOe ? sckOut : peerSck;
  sio_rxtx #(.HALF_BASE(1)) sio_rxtx_i (
    .core_clk(core_clk), .rst_n(rst_n), .clkEn(clkEn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serialClockPinIn(sckWire), .serialClockPinOut(sckOut),
    .serialClockPinOe(sckOe), .serialInPin(sdiPin), .serialOutPin(sdoPin), .serialIrq(serialIrq));
  sio_peer sio_peer_i (.sck(peerSck), .sdo(sdiPin), .devOut(sdoPin), .sckWire(sckWire), .devDrive(sckOe));
  initial core_clk = 1'b0;
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) if (serialIrq === 1'b1) irqCount++;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      $display("unexpected at %0t: run too long", $time);
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checks_done++;
    if (g !== x) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    apb(1'b0, a, 32'h0);
    chk(q, {24'h0, x});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask
  // Edge detection takes three cycles and the interrupt one more
  task automatic send(input logic [7:0] b, input logic lsb);
    sio_peer_i.xfer(b, lsb, got);
    repeat (4) @(posedge core_clk);
  endtask
  task automatic waitIrq();
    while (irqCount == expIrq) @(posedge core_clk);
    expIrq++;
    repeat (16) @(posedge core_clk);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    clkEn = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    errors = 0;
    checks_done = 0;
    irqCount = 0;
    expIrq = 0;
    cycles = 0;
    void'($urandom(32'h1812));
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(`SIO_STAT_OFS, 8'h20);
    rd(`SIO_CTRL_OFS, 8'h00);
    apb(1'b0, 8'h10, 32'h0);
    chk({31'h0, e}, 32'h1);
    $display("test reset done");
    for (int d = 0; d < 2; d++) begin
      tx = 8'($urandom);
      rxq.push_back(8'($urandom));
      wr(`SIO_TXB_OFS, tx);
      rd(`SIO_STAT_OFS, 8'h00);
      wr(`SIO_CTRL_OFS, 8'hA7 | 8'(d << 3));
      send(rxq[0], d[0]);
      expIrq++;
      chk({24'h0, got}, {24'h0, tx});
      rd(`SIO_STAT_OFS, 8'hB0);
      rd(`SIO_RXB_OFS, rxq.pop_front());
      rd(`SIO_STAT_OFS, 8'hA0);
      chk(irqCount, expIrq);
      tx = 8'($urandom);
      rxq.push_back(8'($urandom));
      wr(`SIO_TXB_OFS, tx);
      fork
        send(rxq[0], d[0]);
        begin
          repeat (24) @(posedge core_clk);
          rd(`SIO_STAT_OFS, 8'hE0);
          wr(`SIO_CTRL_OFS, 8'h27 | 8'(d << 3));
        end
      join
      expIrq++;
      chk({24'h0, got}, {24'h0, tx});
      rd(`SIO_RXB_OFS, rxq.pop_front());
      rd(`SIO_STAT_OFS, 8'h20);
      chk({31'h0, sdoPin}, 32'h1);
      send(8'($urandom), d[0]);
      chk({24'h0, got}, 32'hFF);
      chk(irqCount, expIrq);
    end
    $display("test full duplex done");
    wr(`SIO_CTRL_OFS, 8'h97);
    for (int i = 0; i < 3; i++) rxq.push_back(8'($urandom));
    send(rxq[0], 1'b0);
    expIrq++;
    rd(`SIO_STAT_OFS, 8'hB0);
    wr(`SIO_STAT_OFS, 8'h0C);
    rd(`SIO_STAT_OFS, 8'hB0);
    send(rxq[1], 1'b0);
    expIrq++;
    rd(`SIO_STAT_OFS, 8'hB4);
    send(rxq[2], 1'b0);
    chk(irqCount, expIrq);
    wr(`SIO_CTRL_OFS, 8'h17);
    send(8'($urandom), 1'b0);
    rd(`SIO_STAT_OFS, 8'h34);
    rd(`SIO_RXB_OFS, rxq.pop_front());
    rd(`SIO_RXB_OFS, rxq.pop_front());
    void'(rxq.pop_front());
    wr(`SIO_STAT_OFS, 8'h00);
    rd(`SIO_STAT_OFS, 8'h20);
    chk(irqCount, expIrq);
    $display("test overrun done");
    for (int m = 0; m < 4; m += 3) begin
      wr(`SIO_CTRL_OFS, 8'h87 | 8'(m << 4));
      send(8'($urandom), 1'b0);
      chk({24'h0, got}, 32'hFF);
      rd(`SIO_STAT_OFS, 8'h20);
    end
    rx = 8'($urandom);
    wr(`SIO_CTRL_OFS, 8'hA7);
    send(rx, 1'b0);
    expIrq++;
    chk({24'h0, got}, 32'hFF);
    rd(`SIO_STAT_OFS, 8'hB8);
    chk(irqCount, expIrq);
    rd(`SIO_RXB_OFS, rx);
    wr(`SIO_CTRL_OFS, 8'h67);
    rd(`SIO_STAT_OFS, 8'h20);
    rd(`SIO_CTRL_OFS, 8'h27);
    rd(`SIO_RXB_OFS, 8'h00);
    $display("test underrun and abort done");
    rx = 8'($urandom);
    tx = 8'($urandom);
    sio_peer_i.falls = 0;
    sio_peer_i.slvTx = rx;
    wr(`SIO_TXB_OFS, tx);
    wr(`SIO_CTRL_OFS, 8'hA2);
    waitIrq();
    chk({24'h0, sio_peer_i.slvGot}, {24'h0, tx});
    chk({31'h0, sckOut}, 32'h1);
    rd(`SIO_RXB_OFS, rx);
    repeat (16) @(posedge core_clk);
    chk(sio_peer_i.falls, 8);
    tx = 8'($urandom);
    wr(`SIO_TXB_OFS, tx);
    waitIrq();
    chk({24'h0, sio_peer_i.slvGot}, {24'h0, tx});
    chk(sio_peer_i.falls, 16);
    rd(`SIO_RXB_OFS, rx);
    $display("test internal clock done");
    test_done();
  end
endmodule
